//--- include/bcd_div_pkg.sv
// Functional notes
// - divide step adds divisor until decimal overflow
// - count in low four bits, upper bits zero
// - remainder keeps the overflowing sum
// - divisor is never written by this unit
// - all-zero sum counts as overflow, stops
// - divide step leaves decimal carry untouched
// - twelve-digit add, nothing carries into extension
// - left shift moves top digit into extension
// - divisor outside, remainder held inside unit
// - normalised divisor gives at most nine steps
package bcd_div_pkg;
	localparam int unsigned DIGIT_W = 4;
	localparam int unsigned MANT_DIGITS = 12;
	localparam int unsigned MANT_W = DIGIT_W * MANT_DIGITS;
	localparam int unsigned RESULT_W = 16;
	localparam logic [4:0] BCD_MAX_DIGIT = 5'h09;
	localparam logic [4:0] BCD_ADJUST = 5'h06;
	localparam logic [DIGIT_W-1:0] BCD_NINE = 4'h9;
	localparam logic [DIGIT_W-1:0] COUNT_LIMIT = 4'hf;
	localparam logic [DIGIT_W-1:0] COUNT_ONE = 4'h1;
	localparam logic [DIGIT_W-1:0] DIGIT_ZERO = 4'h0;
	localparam logic [MANT_W-1:0] MANT_ZERO = '0;
	localparam logic [RESULT_W-DIGIT_W-1:0] COUNT_UPPER_ZERO = 12'h000;

	typedef enum logic [2:0] {
		load_remainder_op,
		load_extension_op,
		complement_op,
		add_once_op,
		mantissa_left_shift_op,
		divide_step_op
	} op_t;

	typedef struct packed {
		op_t op;
		logic [MANT_W-1:0] data;
	} cmd_t;
endpackage

//--- rtl/bcd_add12.sv
`timescale 1ns/1ps
// ripple BCD adder, one decimal digit per generate slice
module bcd_add12 import bcd_div_pkg::*; #(
	parameter int unsigned DIGITS = MANT_DIGITS
) (
	input wire logic [DIGITS*DIGIT_W-1:0] augend,
	input wire logic [DIGITS*DIGIT_W-1:0] addend,
	output logic [DIGITS*DIGIT_W-1:0] sum,
	output logic carry_out
);
	logic [DIGITS:0] carry;

	assign carry[0] = 1'b0;
	assign carry_out = carry[DIGITS];

	// each slice: binary add, then add six when above nine
	genvar i;
	generate
		for (i = 0; i < DIGITS; i++) begin : g_digit
			wire [4:0] raw;
			wire [4:0] fixed;
			assign raw = {1'b0, augend[i*DIGIT_W +: DIGIT_W]} + {1'b0, addend[i*DIGIT_W +: DIGIT_W]}
				+ {4'h0, carry[i]};
			assign fixed = raw + BCD_ADJUST;
			assign carry[i+1] = raw > BCD_MAX_DIGIT;
			assign sum[i*DIGIT_W +: DIGIT_W] = carry[i+1] ? fixed[DIGIT_W-1:0] : raw[DIGIT_W-1:0];
		end
	endgenerate
endmodule

//--- rtl/bcd_divide_step_unit.sv
`timescale 1ns/1ps
// mantissa datapath for the divide step and its helper operations
module bcd_divide_step_unit import bcd_div_pkg::*; #(
	parameter logic [DIGIT_W-1:0] STEP_LIMIT = COUNT_LIMIT
) (
	input wire logic CLOCK,
	input wire logic RST_B,
	input wire logic OP_VALID,
	input wire cmd_t OP_CMD,
	input wire logic [MANT_W-1:0] DIVISOR,
	output logic BUSY,
	output logic DONE,
	output logic [RESULT_W-1:0] COUNT_RESULT,
	output logic [MANT_W-1:0] REMAINDER,
	output logic [DIGIT_W-1:0] EXT_DIGIT,
	output logic DECIMAL_CARRY_FLAG,
	output logic REMAINDER_ZERO
);
	typedef enum logic {idle_s, step_s} state_t;

	state_t state;
	state_t next_state;
	logic [MANT_W-1:0] remainder_reg;
	logic [MANT_W-1:0] next_remainder;
	logic [DIGIT_W-1:0] extension_reg;
	logic [DIGIT_W-1:0] next_extension;
	logic [DIGIT_W-1:0] step_count;
	logic [DIGIT_W-1:0] next_count;
	logic decimal_carry_flag;
	logic next_carry_flag;
	logic next_done;

	// zero test is needed on the sum and on the next remainder
	function automatic logic mant_is_zero(input logic [MANT_W-1:0] m);
		mant_is_zero = (m == MANT_ZERO);
	endfunction

	// digit-wise nines complement, firmware's tool before a divide step
	function automatic logic [MANT_W-1:0] nines(input logic [MANT_W-1:0] m);
		logic [MANT_W-1:0] r;
		r = MANT_ZERO;
		for (int d = 0; d < MANT_DIGITS; d++) begin
			r[d*DIGIT_W +: DIGIT_W] = BCD_NINE - m[d*DIGIT_W +: DIGIT_W];
		end
		nines = r;
	endfunction

	// the divisor is only an adder operand; nothing here can write it
	wire [MANT_W-1:0] sum;
	wire carry_out;

	bcd_add12 #(
		.DIGITS(MANT_DIGITS)
	) u_add (
		.augend(remainder_reg),
		.addend(DIVISOR),
		.sum(sum),
		.carry_out(carry_out)
	);

	// command decode; a command arriving while busy is ignored
	wire accept = OP_VALID && (state == idle_s);
	wire do_load_rem = accept && (OP_CMD.op == load_remainder_op);
	wire do_load_ext = accept && (OP_CMD.op == load_extension_op);
	wire do_complement = accept && (OP_CMD.op == complement_op);
	wire do_add_once = accept && (OP_CMD.op == add_once_op);
	wire do_shift = accept && (OP_CMD.op == mantissa_left_shift_op);
	wire do_divide = accept && (OP_CMD.op == divide_step_op);
	wire stepping = (state == step_s);

	// a zero sum also ends the step, so the count is one short there
	wire overflow = carry_out || mant_is_zero(sum);
	// the limit only guards against an unnormalised or zero divisor
	wire at_limit = (step_count == STEP_LIMIT);
	wire finish = stepping && (overflow || at_limit);

	// shift: top digit drops into the extension, zero enters below
	wire [MANT_W-1:0] shifted = {remainder_reg[MANT_W-DIGIT_W-1:0], DIGIT_ZERO};
	wire [DIGIT_W-1:0] top_digit = remainder_reg[MANT_W-1 -: DIGIT_W];

	// each step cycle stores the sum, including the overflowing one
	assign next_remainder = stepping ? sum :
		do_load_rem ? OP_CMD.data :
		do_complement ? nines(remainder_reg) :
		do_add_once ? sum :
		do_shift ? shifted :
		remainder_reg;

	// the adder never feeds the extension digit
	assign next_extension = do_shift ? top_digit :
		do_load_ext ? OP_CMD.data[DIGIT_W-1:0] :
		extension_reg;

	// count every in-range addition made before step_count reaches STEP_LIMIT
	assign next_count = do_divide ? DIGIT_ZERO :
		(stepping && !finish) ? step_count + COUNT_ONE :
		step_count;

	// only the single add touches the flag; the divide step does not
	assign next_carry_flag = do_add_once ? carry_out : decimal_carry_flag;

	// sequencer: idle takes commands, step keeps adding until the end condition
	always_comb begin
		next_state = state;
		unique case (state)
			idle_s: begin
				next_state = do_divide ? step_s : idle_s;
			end
			step_s: begin
				next_state = finish ? idle_s : step_s;
			end
		endcase
	end

	// one-cycle ops finish at once, the divide step when it stops
	assign next_done = (accept && !do_divide) || finish;

	// sequencer state
	always_ff @(posedge CLOCK or negedge RST_B) begin
		if (!RST_B) begin
			state <= idle_s;
		end else begin
			state <= next_state;
		end
	end

	// working remainder; the overflowing sum stays here for firmware to repair
	always_ff @(posedge CLOCK or negedge RST_B) begin
		if (!RST_B) begin
			remainder_reg <= MANT_ZERO;
		end else begin
			remainder_reg <= next_remainder;
		end
	end

	// extension digit, written only by the shift and an explicit load
	always_ff @(posedge CLOCK or negedge RST_B) begin
		if (!RST_B) begin
			extension_reg <= DIGIT_ZERO;
		end else begin
			extension_reg <= next_extension;
		end
	end

	// step counter restarts on every divide step
	always_ff @(posedge CLOCK or negedge RST_B) begin
		if (!RST_B) begin
			step_count <= DIGIT_ZERO;
		end else begin
			step_count <= next_count;
		end
	end

	// decimal carry; the divide step overflows but must leave it alone
	always_ff @(posedge CLOCK or negedge RST_B) begin
		if (!RST_B) begin
			decimal_carry_flag <= 1'b0;
		end else begin
			decimal_carry_flag <= next_carry_flag;
		end
	end

	// upper twelve result bits are wired to zero constants in the flop
	always_ff @(posedge CLOCK or negedge RST_B) begin
		if (!RST_B) begin
			COUNT_RESULT <= {COUNT_UPPER_ZERO, DIGIT_ZERO};
		end else begin
			COUNT_RESULT <= {COUNT_UPPER_ZERO, next_count};
		end
	end

	// busy mirrors the sequencer, so a request seen with busy low is taken
	always_ff @(posedge CLOCK or negedge RST_B) begin
		if (!RST_B) begin
			BUSY <= 1'b0;
		end else begin
			BUSY <= (next_state == step_s);
		end
	end

	// done pulses for one cycle when any command finishes
	always_ff @(posedge CLOCK or negedge RST_B) begin
		if (!RST_B) begin
			DONE <= 1'b0;
		end else begin
			DONE <= next_done;
		end
	end

	// remainder copy, loaded from the same next value as the working register
	always_ff @(posedge CLOCK or negedge RST_B) begin
		if (!RST_B) begin
			REMAINDER <= MANT_ZERO;
		end else begin
			REMAINDER <= next_remainder;
		end
	end

	// extension copy
	always_ff @(posedge CLOCK or negedge RST_B) begin
		if (!RST_B) begin
			EXT_DIGIT <= DIGIT_ZERO;
		end else begin
			EXT_DIGIT <= next_extension;
		end
	end

	// carry copy
	always_ff @(posedge CLOCK or negedge RST_B) begin
		if (!RST_B) begin
			DECIMAL_CARRY_FLAG <= 1'b0;
		end else begin
			DECIMAL_CARRY_FLAG <= next_carry_flag;
		end
	end

	// zero test on the value being stored, so flag and remainder move together
	always_ff @(posedge CLOCK or negedge RST_B) begin
		if (!RST_B) begin
			REMAINDER_ZERO <= 1'b1;
		end else begin
			REMAINDER_ZERO <= mant_is_zero(next_remainder);
		end
	end
endmodule

//--- testbench/bcd_div_monitor.sv
`timescale 1ns/1ps
// watches the datapath ports only
module bcd_div_monitor import bcd_div_pkg::*; #(
	parameter logic [DIGIT_W-1:0] STEP_LIMIT = COUNT_LIMIT
) (
	input wire logic CLOCK,
	input wire logic RST_B,
	input wire logic OP_VALID,
	input wire cmd_t OP_CMD,
	input wire logic BUSY,
	input wire logic DONE,
	input wire logic [RESULT_W-1:0] COUNT_RESULT,
	input wire logic [MANT_W-1:0] REMAINDER,
	input wire logic [DIGIT_W-1:0] EXT_DIGIT,
	input wire logic DECIMAL_CARRY_FLAG
);
	default clocking @(posedge CLOCK); endclocking
	default disable iff (!RST_B);
	// a request counts only while idle; requests while busy are lost
	wire take = OP_VALID && !BUSY;
	wire dstep = take && OP_CMD.op == divide_step_op;
	wire shift = take && OP_CMD.op == mantissa_left_shift_op;
	// at the safety limit the end rule differs, so the count check stops short of it
	wire below = {1'b0, COUNT_RESULT[3:0]} + 5'h01 < {1'b0, STEP_LIMIT};
	a_upper_zero: assert property (COUNT_RESULT[15:4] == 12'h000) else $error("count upper bits set");
	a_step_start: assert property (dstep |=> BUSY && COUNT_RESULT == 16'h0000) else $error("step start");
	a_step_bound: assert property (dstep |-> ##[2:17] DONE) else $error("step too long");
	a_count_up: assert property (BUSY && below |=>
		(DONE ? $stable(COUNT_RESULT) : COUNT_RESULT == $past(COUNT_RESULT) + 16'h0001)) else $error("count step");
	a_carry_kept: assert property (BUSY |=> $stable(DECIMAL_CARRY_FLAG)) else $error("carry moved");
	a_ext_kept: assert property (BUSY |=> $stable(EXT_DIGIT)) else $error("extension moved");
	a_busy_done: assert property ($fell(BUSY) |-> DONE) else $error("end without done");
	a_shift_top: assert property (shift |=> EXT_DIGIT == $past(REMAINDER[47:44])
		&& REMAINDER == {$past(REMAINDER[43:0]), 4'h0}) else $error("shift");
	c_step: cover property (dstep);
	c_zero: cover property (DONE && REMAINDER == MANT_ZERO);
	c_shift: cover property (shift);
endmodule
bind bcd_divide_step_unit bcd_div_monitor #(.STEP_LIMIT(STEP_LIMIT)) mon_u (.CLOCK, .RST_B, .OP_VALID,
	.OP_CMD, .BUSY, .DONE, .COUNT_RESULT, .REMAINDER, .EXT_DIGIT, .DECIMAL_CARRY_FLAG);

//--- testbench/fw_side.sv
`timescale 1ns/1ps
// firmware side: the divisor word lives outside the unit
module fw_side import bcd_div_pkg::*; (
	input wire logic clk,
	input wire logic [MANT_W-1:0] value,
	output logic [MANT_W-1:0] divisor
);
	// updated just after an edge and only between operations
	always_ff @(posedge clk) divisor <= value;
endmodule

//--- testbench/tb_top.sv
`timescale 1ns/1ps
module tb_top import bcd_div_pkg::*;;
	localparam longint T = 64'd1000000000000;
	logic CLOCK = 0, RST_B = 0, OP_VALID = 0;
	cmd_t OP_CMD = '0;
	logic [MANT_W-1:0] dvr_in = '0, DIVISOR, REMAINDER;
	logic BUSY, DONE, DECIMAL_CARRY_FLAG, REMAINDER_ZERO;
	logic [RESULT_W-1:0] COUNT_RESULT;
	logic [DIGIT_W-1:0] EXT_DIGIT;
	int n_mismatch = 0, n_tests = 0, cyc = 0;
	bcd_divide_step_unit dut_u (
		.CLOCK(CLOCK),
		.RST_B(RST_B),
		.OP_VALID(OP_VALID),
		.OP_CMD(OP_CMD),
		.DIVISOR(DIVISOR),
		.BUSY(BUSY),
		.DONE(DONE),
		.COUNT_RESULT(COUNT_RESULT),
		.REMAINDER(REMAINDER),
		.EXT_DIGIT(EXT_DIGIT),
		.DECIMAL_CARRY_FLAG(DECIMAL_CARRY_FLAG),
		.REMAINDER_ZERO(REMAINDER_ZERO)
	);
	fw_side fw_u (.clk(CLOCK), .value(dvr_in), .divisor(DIVISOR));
	initial forever #4 CLOCK = ~CLOCK;
	// hang guard, far above the under two hundred cycles the run needs
	always @(posedge CLOCK) if (++cyc == 3000) begin
		n_mismatch++;
		end_of_test;
	end
	task automatic end_of_test;
		if (n_mismatch == 0 && n_tests > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	task automatic chk(string nm, logic [47:0] e, logic [47:0] g);
		n_tests++;
		if (g !== e) begin
			n_mismatch++;
			$display("mismatch %s exp %h got %h", nm, e, g);
		end
	endtask
	function automatic logic [47:0] bcd(longint v);
		logic [47:0] b;
		for (int i = 0; i < 12; i++) begin
			b[i*4+:4] = 4'(v % 10);
			v = v / 10;
		end
		return b;
	endfunction
	// one request, held until its edge, then a bounded wait for done
	task automatic op(op_t o, logic [47:0] d);
		OP_VALID = 1;
		OP_CMD = '{o, d};
		@(posedge CLOCK) #1 OP_VALID = 0;
		repeat (20) if (DONE !== 1'b1) @(posedge CLOCK) #1;
		chk("done", 1'h1, DONE);
		// one quiet edge, so the next request never re-raises valid in this step
		@(posedge CLOCK) #1;
	endtask
	// expected count stops at overflow or at an all-zero sum
	task automatic step(longint v, longint d, bit cpl);
		longint r, s;
		int n;
		logic c;
		logic [3:0] x;
		r = cpl ? T - 1 - v : v;
		n = 0;
		s = r + d;
		while (s < T && s != 0) begin
			r = s;
			n++;
			s = r + d;
		end
		dvr_in = bcd(d);
		op(load_remainder_op, bcd(v));
		if (cpl) op(complement_op, '0);
		c = DECIMAL_CARRY_FLAG;
		x = EXT_DIGIT;
		op(divide_step_op, '0);
		chk("count", 48'(n), COUNT_RESULT);
		chk("rem", bcd(s % T), REMAINDER);
		chk("carry", c, DECIMAL_CARRY_FLAG);
		chk("ext", x, EXT_DIGIT);
	endtask
	// firmware long division: a digit per pass, stopping on a zero remainder
	task automatic divide_run(longint v, longint d, int nd, logic [47:0] q_exp, int n_exp);
		logic [47:0] q;
		logic [3:0] e;
		int b, k;
		bit stop;
		q = '0;
		k = 0;
		stop = 0;
		dvr_in = bcd(d);
		op(load_remainder_op, bcd(v));
		op(load_extension_op, 48'h9);
		op(complement_op, '0);
		while (k < nd && !stop) begin
			b = 0;
			// one step per extension count until the thirteen-digit pass overflows
			do begin
				op(divide_step_op, '0);
				b = b + int'(COUNT_RESULT[3:0]) + 1;
				e = EXT_DIGIT + 4'h1;
				op(load_extension_op, 48'(e));
			end while (e != 4'ha);
			k++;
			stop = REMAINDER_ZERO;
			q = {q[43:0], stop ? 4'(b) : 4'(b - 1)};
			if (!stop) begin
				op(complement_op, '0);
				op(add_once_op, '0);
				op(mantissa_left_shift_op, '0);
				op(complement_op, '0);
				op(load_extension_op, 48'(4'h9 - EXT_DIGIT));
			end
		end
		chk("quotient", q_exp, q);
		chk("digits", 48'(n_exp), 48'(k));
	endtask
	// in-range counts on a complemented dividend, one of them zero
	task automatic t_counts;
		step(64'd480000000000, 64'd150000000000, 1);
		step(64'd100000000000, 64'd150000000000, 1);
	endtask
	// an overflow that leaves a zero sum, and a zero sum with no carry
	task automatic t_zero_sum;
		step(64'd700000000000, 64'd150000000000, 0);
		chk("zero", 1'h1, REMAINDER_ZERO);
		step(0, 0, 0);
	endtask
	// left shift drops the top digit into the extension
	task automatic t_shift;
		op(load_remainder_op, 48'h712345678901);
		op(mantissa_left_shift_op, '0);
		chk("shift", 48'h123456789010, REMAINDER);
		chk("top", 4'h7, EXT_DIGIT);
	endtask
	// single add sets the carry, then a divide step must keep it
	task automatic t_add_carry;
		dvr_in = 48'h000000000001;
		op(load_remainder_op, 48'h999999999999);
		op(add_once_op, '0);
		chk("addc", 1'h1, DECIMAL_CARRY_FLAG);
		chk("adds", 48'h000000000000, REMAINDER);
		step(64'd999999999999, 1, 0);
	endtask
	// repeating quotient with thirteen-digit passes, then a perfect quotient
	task automatic t_divide;
		divide_run(64'd100000000000, 64'd150000000000, 4, 48'h000000000666, 4);
		divide_run(64'd299999999999, 64'd150000000000, 4, 48'h000000000002, 1);
	endtask
	initial begin
		repeat (20) @(posedge CLOCK);
		#1 RST_B = 1;
		t_counts;
		t_zero_sum;
		t_shift;
		t_add_carry;
		t_divide;
		end_of_test;
	end
endmodule
